// *** inc/ulsm_defs.svh ***
// Register offsets, bit positions, reset values and counts of the line status block.
`ifndef ULSM_DEFS_SVH
`define ULSM_DEFS_SVH
`define ULSM_OFS_LINE_STATUS 5'h00
`define ULSM_OFS_MODEM_CTRL 5'h04
`define ULSM_OFS_IRQ_STATUS 5'h08
`define ULSM_OFS_IRQ_MASK 5'h0C
`define ULSM_OFS_ENH_FEAT 5'h10
`define ULSM_OFS_RX_HOLDING 5'h14
`define ULSM_OFS_FLOW_THR 5'h18
`define ULSM_OFS_TRIG_LVL 5'h1C
`define ULSM_MCR_CLKSEL 7
`define ULSM_MCR_THR_ACC 6
`define ULSM_MCR_XON_ANY 5
`define ULSM_MCR_LOOP 4
`define ULSM_EFR_WEN 4
`define ULSM_MCR_RESET 8'h00
`define ULSM_REG8_RESET 8'h00
`define ULSM_IRQ_OVR 0
`define ULSM_IRQ_ERR 1
`define ULSM_IRQ_BRK 2
`define ULSM_PRESCALE_DIV 2'h3
`define ULSM_ERRCNT_MAX 7'h40
`endif

// *** inc/ulsm_pkg.sv ***
// Types shared by the line status and modem control block.
package ulsm_pkg;
   // One received character with its error tags, as written into the receive FIFO.
   typedef struct packed {
      logic valid;
      logic brk;
      logic fe;
      logic pe;
      logic [7:0] data;
   } ulsm_rxchar_t;

   // Error tags of the character at the receive FIFO head.
   typedef struct packed {
      logic brk;
      logic fe;
      logic pe;
   } ulsm_tags_t;

   // State of the top module, apart from the reset synchronizer.
   typedef struct packed {
      logic wreq;
      logic [31:0] rdata;
      logic [7:0] modem_control;
      logic efr_wen;
      logic [7:0] flow_threshold_ctrl;
      logic [7:0] trigger_level_ctrl;
      logic ovr;
      logic [2:0] ist;
      logic [2:0] imask;
      logic irq;
      logic pop;
      ulsm_rxchar_t push;
      logic resume;
      logic txd;
      logic rxd;
      logic [3:0] msr_hi;
      logic rts_n;
      logic dtr_n;
   } ulsm_top_st_t;

   // State of the prescaler.
   typedef struct packed {
      logic [1:0] cnt;
      logic tick;
   } ulsm_pre_st_t;

   // State of the FIFO error counter.
   typedef struct packed {
      logic [6:0] cnt;
      logic any;
   } ulsm_cnt_st_t;
endpackage : ulsm_pkg

// *** rtl/ulsm_prescale.sv ***
// Baud clock prescaler: passes every cycle or every fourth cycle as an enable pulse.
`timescale 1ns/10ps
`include "ulsm_defs.svh"
module ulsm_prescale
   import ulsm_pkg::*;
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Control and tick.
   input wire logic div4_i,
   output logic tick_o
);
   ulsm_pre_st_t s_q, s_d;

   // Count freely; the tick is every cycle undivided, else once per four cycles.
   always_comb begin
      s_d = s_q;
      s_d.cnt = s_q.cnt + 2'h1;
      s_d.tick = div4_i ? (s_q.cnt == `ULSM_PRESCALE_DIV) : 1'b1;
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick_o = s_q.tick;
endmodule : ulsm_prescale

// *** rtl/ulsm_err_count.sv ***
// Counts receive FIFO entries that carry any error tag.
`timescale 1ns/10ps
`include "ulsm_defs.svh"
module ulsm_err_count
   import ulsm_pkg::*;
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_n_i,
   // Entry events.
   input wire logic clr_i,
   input wire logic inc_i,
   input wire logic dec_i,
   output logic any_o
);
   ulsm_cnt_st_t s_q, s_d;

   // A push and a pop in one cycle cancel; a FIFO clear drops every entry.
   always_comb begin
      s_d = s_q;
      if (clr_i) begin
         s_d.cnt = 7'h00;
      end else if (inc_i && !dec_i && s_q.cnt != `ULSM_ERRCNT_MAX) begin
         s_d.cnt = s_q.cnt + 7'h01;
      end else if (dec_i && !inc_i && s_q.cnt != 7'h00) begin
         s_d.cnt = s_q.cnt - 7'h01;
      end
      s_d.any = (s_d.cnt != 7'h00);
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign any_o = s_q.any;
endmodule : ulsm_err_count

// *** rtl/ulsm_top.sv ***
// Line status reporting and modem control for one UART channel, on Avalon-MM.
//
// Operation
// - FIFO error bit tracks errored entries in FIFO.
// - Transmitter empty when holding and shifter empty.
// - Holding empty flag; host may write 64.
// - Full low frame stores zero with break.
// - Missing stop bit tags a framing error.
// - Failed parity check tags a parity error.
// - Overrun bit set whenever an overrun occurs.
// - Data-available bit high while FIFO not empty.
// - Head tags drive break, framing, parity bits.
// - Status read never advances FIFO read pointer.
// - Clock select bit divides input by four.
// - Access bit opens threshold and trigger registers.
// - Xon-any resumes transmission on any character.
// - Loopback clear keeps external pins connected.
// - Loopback routes modem bits and serial data.
// - Top three control bits need write enable.
//
// The Avalon-MM slave port and the address map were left to the implementer.
`timescale 1ns/10ps
`include "ulsm_defs.svh"
module ulsm_top
   import ulsm_pkg::*;
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic resetn_i,
   // Avalon-MM register slave.
   input wire logic [4:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   output logic [31:0] avs_readdata_o,
   output logic avs_waitrequest_o,
   // Characters from the receive framer.
   input wire logic rx_valid_i,
   input wire logic [7:0] rx_data_i,
   input wire logic rx_stop_ok_i,
   input wire logic rx_parity_ok_i,
   input wire logic rx_break_i,
   // Receive FIFO side.
   output ulsm_rxchar_t rx_push_o,
   output logic rx_pop_o,
   input wire ulsm_tags_t rx_head_i,
   input wire logic rx_empty_i,
   input wire logic rx_fifo_clr_i,
   input wire logic rx_overrun_i,
   // Transmitter state and serial paths.
   input wire logic tx_hold_empty_i,
   input wire logic tx_shift_empty_i,
   input wire logic tx_core_i,
   output logic tx_pin_o,
   input wire logic rx_pin_i,
   output logic rx_core_o,
   // Modem lines.
   input wire logic cts_n_i,
   input wire logic dsr_n_i,
   input wire logic ri_n_i,
   input wire logic cd_n_i,
   output logic rts_n_o,
   output logic dtr_n_o,
   output logic [3:0] modem_hi_o,
   // Controls to the rest of the core.
   output logic baud_en_o,
   output logic xon_any_o,
   output logic xon_resume_o,
   output logic thresh_access_o,
   output logic irq_o
);
   logic [1:0] rst_sync_q;
   logic rst_n;
   ulsm_top_st_t s_q, s_d;
   logic fifo_err;
   logic baud_tick;
   logic req;
   logic snap;
   logic done;
   logic wr0;
   logic rd_status;
   logic rd_holding;
   logic err_push;
   logic err_pop;
   logic [7:0] line_status;
   logic [31:0] rmux;
   logic [2:0] ev;

   // Reset is taken asynchronously and released through two flip-flops.
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_q[1];

   // A request is snapped in its first cycle and completed in its second.
   assign req = avs_read_i | avs_write_i;
   assign snap = req & s_q.wreq;
   assign done = req & ~s_q.wreq;
   assign wr0 = done & avs_write_i & avs_byteenable_i[0];
   assign rd_status = snap & avs_read_i & (avs_address_i == `ULSM_OFS_LINE_STATUS);
   assign rd_holding = snap & avs_read_i & (avs_address_i == `ULSM_OFS_RX_HOLDING);

   // Error bookkeeping for entries entering and leaving the receive FIFO.
   assign err_push = s_q.push.valid & (s_q.push.brk | s_q.push.fe | s_q.push.pe);
   assign err_pop = rd_holding & ~rx_empty_i & (rx_head_i.brk | rx_head_i.fe | rx_head_i.pe);

   ulsm_err_count u_err_count (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .clr_i(rx_fifo_clr_i),
      .inc_i(err_push),
      .dec_i(err_pop),
      .any_o(fifo_err)
   );

   ulsm_prescale u_prescale (
      .clk_i(clk_i),
      .rst_n_i(rst_n),
      .div4_i(s_q.modem_control[`ULSM_MCR_CLKSEL]),
      .tick_o(baud_tick)
   );

   // Head tags are never stored here; they pass straight onto the read data.
   always_comb begin
      line_status = 8'h00;
      line_status[7] = fifo_err;
      line_status[6] = tx_hold_empty_i & tx_shift_empty_i;
      line_status[5] = tx_hold_empty_i;
      line_status[4:2] = rx_empty_i ? 3'h0 : rx_head_i;
      line_status[1] = s_q.ovr;
      line_status[0] = ~rx_empty_i;
   end

   // Read multiplexer; unmapped and closed addresses read as zero.
   always_comb begin
      rmux = 32'h0000_0000;
      case (avs_address_i)
         `ULSM_OFS_LINE_STATUS: rmux[7:0] = line_status;
         `ULSM_OFS_MODEM_CTRL: rmux[7:0] = s_q.modem_control;
         `ULSM_OFS_IRQ_STATUS: rmux[2:0] = s_q.ist;
         `ULSM_OFS_IRQ_MASK: rmux[2:0] = s_q.imask;
         `ULSM_OFS_ENH_FEAT: rmux[`ULSM_EFR_WEN] = s_q.efr_wen;
         `ULSM_OFS_RX_HOLDING: rmux[7:0] = 8'h00;
         `ULSM_OFS_FLOW_THR: rmux[7:0] = s_q.modem_control[`ULSM_MCR_THR_ACC] ? s_q.flow_threshold_ctrl : 8'h00;
         `ULSM_OFS_TRIG_LVL: rmux[7:0] = s_q.modem_control[`ULSM_MCR_THR_ACC] ? s_q.trigger_level_ctrl : 8'h00;
         default: rmux = 32'h0000_0000;
      endcase
   end

   // Interrupt events: overrun, an errored character and a break character.
   assign ev = {s_q.push.valid & s_q.push.brk, err_push, rx_overrun_i};

   always_comb begin
      s_d = s_q;
      // Waitrequest drops for exactly one cycle per request.
      s_d.wreq = ~snap;
      if (snap) begin
         s_d.rdata = avs_read_i ? rmux : 32'h0000_0000;
      end
      // Overrun: a new event in the clearing cycle wins over the read clear.
      s_d.ovr = (s_q.ovr & ~rd_status) | rx_overrun_i;
      // Only a holding register read pops; a status read leaves the pointer alone.
      s_d.pop = rd_holding & ~rx_empty_i;
      // Register writes land on the completing edge.
      if (wr0) begin
         case (avs_address_i)
            `ULSM_OFS_MODEM_CTRL: begin
               s_d.modem_control[4:0] = avs_writedata_i[4:0];
               if (s_q.efr_wen) begin
                  s_d.modem_control[7:5] = avs_writedata_i[7:5];
               end
            end
            `ULSM_OFS_IRQ_MASK: s_d.imask = avs_writedata_i[2:0];
            `ULSM_OFS_ENH_FEAT: s_d.efr_wen = avs_writedata_i[`ULSM_EFR_WEN];
            `ULSM_OFS_FLOW_THR: begin
               if (s_q.modem_control[`ULSM_MCR_THR_ACC]) begin
                  s_d.flow_threshold_ctrl = avs_writedata_i[7:0];
               end
            end
            `ULSM_OFS_TRIG_LVL: begin
               if (s_q.modem_control[`ULSM_MCR_THR_ACC]) begin
                  s_d.trigger_level_ctrl = avs_writedata_i[7:0];
               end
            end
            default: s_d.modem_control = s_q.modem_control;
         endcase
      end
      // Sticky interrupt status, write one to clear, events win.
      if (wr0 && avs_address_i == `ULSM_OFS_IRQ_STATUS) begin
         s_d.ist = s_q.ist & ~avs_writedata_i[2:0];
      end
      s_d.ist = s_d.ist | ev;
      s_d.irq = |(s_d.ist & s_d.imask);
      // Tag each received character; a break frame becomes a zero character.
      s_d.push.valid = rx_valid_i;
      s_d.push.brk = rx_break_i;
      s_d.push.data = rx_break_i ? 8'h00 : rx_data_i;
      s_d.push.fe = ~rx_break_i & ~rx_stop_ok_i;
      s_d.push.pe = ~rx_break_i & ~rx_parity_ok_i;
      s_d.resume = rx_valid_i & s_q.modem_control[`ULSM_MCR_XON_ANY];
      // Loopback cuts the pins off and feeds the core from itself.
      if (s_q.modem_control[`ULSM_MCR_LOOP]) begin
         s_d.txd = 1'b1;
         s_d.rxd = tx_core_i;
         s_d.msr_hi = {s_q.modem_control[3], s_q.modem_control[2], s_q.modem_control[0], s_q.modem_control[1]};
         s_d.rts_n = 1'b1;
         s_d.dtr_n = 1'b1;
      end else begin
         s_d.txd = tx_core_i;
         s_d.rxd = rx_pin_i;
         s_d.msr_hi = ~{cd_n_i, ri_n_i, dsr_n_i, cts_n_i};
         s_d.rts_n = ~s_q.modem_control[1];
         s_d.dtr_n = ~s_q.modem_control[0];
      end
   end

   // The whole state registers on one edge; pins idle high after reset.
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         s_q <= '0;
         s_q.wreq <= 1'b1;
         s_q.modem_control <= `ULSM_MCR_RESET;
         s_q.flow_threshold_ctrl <= `ULSM_REG8_RESET;
         s_q.trigger_level_ctrl <= `ULSM_REG8_RESET;
         s_q.txd <= 1'b1;
         s_q.rxd <= 1'b1;
         s_q.rts_n <= 1'b1;
         s_q.dtr_n <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs come straight from flip-flops.
   assign avs_readdata_o = s_q.rdata;
   assign avs_waitrequest_o = s_q.wreq;
   assign rx_push_o = s_q.push;
   assign rx_pop_o = s_q.pop;
   assign tx_pin_o = s_q.txd;
   assign rx_core_o = s_q.rxd;
   assign rts_n_o = s_q.rts_n;
   assign dtr_n_o = s_q.dtr_n;
   assign modem_hi_o = s_q.msr_hi;
   assign baud_en_o = baud_tick;
   assign xon_any_o = s_q.modem_control[`ULSM_MCR_XON_ANY];
   assign xon_resume_o = s_q.resume;
   assign thresh_access_o = s_q.modem_control[`ULSM_MCR_THR_ACC];
   assign irq_o = s_q.irq;

   // Checks on the behaviour above.
   sequence s_status_snap;
      avs_read_i && avs_waitrequest_o && avs_address_i == `ULSM_OFS_LINE_STATUS;
   endsequence

   sequence s_answer;
      !avs_waitrequest_o;
   endsequence

   property p_fifo_err;
      @(posedge clk_i) disable iff (!rst_n)
      s_status_snap ##1 s_answer |-> avs_readdata_o[7] == $past(fifo_err);
   endproperty
   a_fifo_err: assert property (p_fifo_err) else $error("FIFO error bit wrong.");

   property p_tx_empty;
      @(posedge clk_i) disable iff (!rst_n)
      s_status_snap |=> avs_readdata_o[6] == ($past(tx_hold_empty_i) && $past(tx_shift_empty_i));
   endproperty
   a_tx_empty: assert property (p_tx_empty) else $error("Transmit empty bit wrong.");

   property p_data_avail;
      @(posedge clk_i) disable iff (!rst_n)
      s_status_snap |=> avs_readdata_o[0] == !$past(rx_empty_i);
   endproperty
   a_data_avail: assert property (p_data_avail) else $error("Data bit wrong.");

   property p_no_pop;
      @(posedge clk_i) disable iff (!rst_n)
      s_status_snap |=> !rx_pop_o;
   endproperty
   a_no_pop: assert property (p_no_pop) else $error("Status read popped FIFO.");

   property p_ovr_clear;
      @(posedge clk_i) disable iff (!rst_n)
      (s_status_snap and !rx_overrun_i) |=> !s_q.ovr;
   endproperty
   a_ovr_clear: assert property (p_ovr_clear) else $error("Overrun not cleared.");

   property p_ovr_set;
      @(posedge clk_i) disable iff (!rst_n)
      rx_overrun_i |=> s_q.ovr && s_q.ist[`ULSM_IRQ_OVR];
   endproperty
   a_ovr_set: assert property (p_ovr_set) else $error("Overrun lost.");

   property p_break_zero;
      @(posedge clk_i) disable iff (!rst_n)
      rx_valid_i && rx_break_i |=> rx_push_o.valid && rx_push_o.brk && rx_push_o.data == 8'h00;
   endproperty
   a_break_zero: assert property (p_break_zero) else $error("Break not stored.");

   property p_mcr_lock;
      @(posedge clk_i) disable iff (!rst_n)
      !s_q.efr_wen |=> $stable(s_q.modem_control[7:5]);
   endproperty
   a_mcr_lock: assert property (p_mcr_lock) else $error("Locked bits changed.");

   property p_loop;
      @(posedge clk_i) disable iff (!rst_n)
      s_q.modem_control[`ULSM_MCR_LOOP] && $stable(s_q.modem_control) |=> rx_core_o == $past(tx_core_i)
         && modem_hi_o == $past({s_q.modem_control[3], s_q.modem_control[2], s_q.modem_control[0], s_q.modem_control[1]});
   endproperty
   a_loop: assert property (p_loop) else $error("Loopback path wrong.");

   property p_xon;
      @(posedge clk_i) disable iff (!rst_n)
      rx_valid_i |=> xon_resume_o == $past(s_q.modem_control[`ULSM_MCR_XON_ANY]);
   endproperty
   a_xon: assert property (p_xon) else $error("Xon-any resume wrong.");
endmodule : ulsm_top

// *** bench/ulsm_fifo_model.sv ***
// Behavioural receive FIFO standing behind the block's FIFO port.
`timescale 1ns/10ps
module ulsm_fifo_model
   import ulsm_pkg::*;
(
   // Clock.
   input wire logic clk_i,
   // Block side.
   input wire ulsm_rxchar_t push_i,
   input wire logic pop_i,
   input wire logic clr_i,
   output ulsm_tags_t head_o,
   output logic empty_o
);
   ulsm_rxchar_t mem_q[$];

   // An empty FIFO shows all tags set, so the block has to mask them itself.
   initial begin
      empty_o = 1'h1;
      head_o = 3'h7;
   end

   // Clear wins over pop and push; a pop of an empty FIFO is ignored.
   always @(posedge clk_i) begin
      if (clr_i) begin
         mem_q.delete();
      end else begin
         if (pop_i && mem_q.size() > 0) begin
            void'(mem_q.pop_front());
         end
         if (push_i.valid) begin
            mem_q.push_back(push_i);
         end
      end
      empty_o <= (mem_q.size() == 0);
      head_o <= (mem_q.size() == 0) ? 3'h7 : {mem_q[0].brk, mem_q[0].fe, mem_q[0].pe};
   end
endmodule : ulsm_fifo_model

// *** bench/tb_uart_line_status_modem_ctrl.sv ***
// Self-checking bench for the line status and modem control block.
`timescale 1ns/10ps
`include "ulsm_defs.svh"
module tb_uart_line_status_modem_ctrl
   import ulsm_pkg::*;
;
   logic clk_i = 1'h0;
   logic resetn_i = 1'h0;
   logic [4:0] adr = 5'h00;
   logic rd = 1'h0;
   logic wr = 1'h0;
   logic [31:0] wdat = 32'h0;
   logic [3:0] ben = 4'hF;
   logic [31:0] rdat;
   logic wreq;
   logic rxv = 1'h0;
   logic [7:0] rxd = 8'h00;
   logic sok = 1'h1;
   logic pok = 1'h1;
   logic brk = 1'h0;
   ulsm_rxchar_t push;
   logic pop;
   ulsm_tags_t head;
   logic emp;
   logic clr = 1'h0;
   logic ovr = 1'h0;
   logic hemp = 1'h1;
   logic semp = 1'h1;
   logic txc = 1'h1;
   logic rxp = 1'h1;
   logic [3:0] mpin = 4'hF;
   logic txp, rxc, rts, dtr, baud, xany, xres, tacc, irq;
   logic [3:0] mhi;
   logic [31:0] q;
   logic [7:0] exp_ls [5] = '{8'hE1, 8'hE5, 8'hE9, 8'hF1, 8'h60};
   int err_total = 0;
   int total_checks = 0;
   int n;

   // Free running 50 MHz clock.
   always #10 clk_i = ~clk_i;

   ulsm_top u_ulsm_top (.clk_i(clk_i), .resetn_i(resetn_i), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(ben),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .rx_valid_i(rxv), .rx_data_i(rxd),
      .rx_stop_ok_i(sok), .rx_parity_ok_i(pok), .rx_break_i(brk), .rx_push_o(push),
      .rx_pop_o(pop), .rx_head_i(head), .rx_empty_i(emp), .rx_fifo_clr_i(clr),
      .rx_overrun_i(ovr), .tx_hold_empty_i(hemp), .tx_shift_empty_i(semp),
      .tx_core_i(txc), .tx_pin_o(txp), .rx_pin_i(rxp), .rx_core_o(rxc),
      .cts_n_i(mpin[0]), .dsr_n_i(mpin[1]), .ri_n_i(mpin[2]), .cd_n_i(mpin[3]),
      .rts_n_o(rts), .dtr_n_o(dtr), .modem_hi_o(mhi), .baud_en_o(baud),
      .xon_any_o(xany), .xon_resume_o(xres), .thresh_access_o(tacc), .irq_o(irq));

   ulsm_fifo_model u_ulsm_fifo_model (.clk_i(clk_i), .push_i(push), .pop_i(pop),
      .clr_i(clr), .head_o(head), .empty_o(emp));

   // Count and report one comparison.
   task chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // One Avalon-MM access; the request stands until the edge at which waitrequest
   // is sampled low, where read data is taken and only then the request dropped.
   task bus(input logic w, input logic [4:0] a, input logic [7:0] d);
      @(posedge clk_i);
      adr <= a;
      wdat <= {24'h0, d};
      wr <= w;
      rd <= ~w;
      @(posedge clk_i);
      while (wreq !== 1'h0) @(posedge clk_i);
      q = rdat;
      rd <= 1'h0;
      wr <= 1'h0;
   endtask : bus

   // Read one register and compare the whole bus word.
   task rdchk(input logic [4:0] a, input logic [7:0] e);
      bus(1'h0, a, 8'h00);
      chk(q, {24'h0, e});
   endtask : rdchk

   // One character from the framer, a single-cycle strobe.
   task put(input logic [7:0] d, input logic so, input logic po, input logic b);
      @(posedge clk_i);
      rxv <= 1'h1;
      rxd <= d;
      sok <= so;
      pok <= po;
      brk <= b;
      @(posedge clk_i);
      rxv <= 1'h0;
   endtask : put

   // Let registered outputs settle, ending mid-cycle where they are stable.
   task idle(input int c);
      repeat (c) @(posedge clk_i);
      @(negedge clk_i);
   endtask : idle

   // Single place where the run ends.
   task finish_test;
      $display("checks=%0d mismatches=%0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : finish_test

   // The tests need well under a thousand cycles; five thousand means a hang.
   initial begin
      repeat (5000) @(posedge clk_i);
      err_total++;
      finish_test;
   end

   // Test sequence.
   initial begin
      repeat (4) @(posedge clk_i);
      resetn_i <= 1'h1;
      repeat (3) @(posedge clk_i);
      rdchk(`ULSM_OFS_LINE_STATUS, 8'h60);
      rdchk(`ULSM_OFS_MODEM_CTRL, `ULSM_MCR_RESET);
      semp <= 1'h0;
      rdchk(`ULSM_OFS_LINE_STATUS, 8'h20);
      hemp <= 1'h0;
      rdchk(`ULSM_OFS_LINE_STATUS, 8'h00);
      hemp <= 1'h1;
      semp <= 1'h1;
      $display("test tx_flags done");
      put(8'h55, 1'h1, 1'h1, 1'h0);
      put(8'h66, 1'h1, 1'h0, 1'h0);
      put(8'h77, 1'h0, 1'h1, 1'h0);
      put(8'hA5, 1'h1, 1'h1, 1'h1);
      idle(3);
      chk(u_ulsm_fifo_model.mem_q[3].data, 8'h00);
      chk(u_ulsm_fifo_model.mem_q[3].brk, 1'h1);
      for (int i = 0; i < 5; i++) begin
         rdchk(`ULSM_OFS_LINE_STATUS, exp_ls[i]);
         rdchk(`ULSM_OFS_LINE_STATUS, exp_ls[i]);
         bus(1'h0, `ULSM_OFS_RX_HOLDING, 8'h00);
      end
      $display("test rx_errors done");
      ovr <= 1'h1;
      @(posedge clk_i);
      ovr <= 1'h0;
      rdchk(`ULSM_OFS_LINE_STATUS, 8'h62);
      rdchk(`ULSM_OFS_LINE_STATUS, 8'h60);
      rdchk(`ULSM_OFS_IRQ_STATUS, 8'h07);
      chk(irq, 1'h0);
      bus(1'h1, `ULSM_OFS_IRQ_MASK, 8'h07);
      idle(2);
      chk(irq, 1'h1);
      bus(1'h1, `ULSM_OFS_IRQ_STATUS, 8'h07);
      idle(2);
      chk(irq, 1'h0);
      rdchk(`ULSM_OFS_IRQ_STATUS, 8'h00);
      $display("test overrun_irq done");
      bus(1'h1, `ULSM_OFS_MODEM_CTRL, 8'hF0);
      rdchk(`ULSM_OFS_MODEM_CTRL, 8'h10);
      bus(1'h1, `ULSM_OFS_ENH_FEAT, 8'h10);
      bus(1'h1, `ULSM_OFS_MODEM_CTRL, 8'hF0);
      rdchk(`ULSM_OFS_MODEM_CTRL, 8'hF0);
      txc <= 1'h0;
      idle(2);
      chk(xany, 1'h1);
      chk(tacc, 1'h1);
      chk(txp, 1'h1);
      chk(rxc, 1'h0);
      n = 0;
      repeat (8) begin
         @(negedge clk_i);
         n += baud;
      end
      chk(32'(n), 32'h2);
      bus(1'h1, `ULSM_OFS_FLOW_THR, 8'h5A);
      rdchk(`ULSM_OFS_FLOW_THR, 8'h5A);
      bus(1'h1, `ULSM_OFS_TRIG_LVL, 8'h3C);
      rdchk(`ULSM_OFS_TRIG_LVL, 8'h3C);
      put(8'h11, 1'h1, 1'h1, 1'h0);
      @(negedge clk_i);
      chk(xres, 1'h1);
      bus(1'h1, `ULSM_OFS_MODEM_CTRL, 8'hF9);
      idle(2);
      chk(mhi, 4'hA);
      chk({rts, dtr}, 2'h3);
      $display("test loopback done");
      bus(1'h1, `ULSM_OFS_MODEM_CTRL, 8'h03);
      rxp <= 1'h0;
      mpin <= 4'hE;
      clr <= 1'h1;
      @(posedge clk_i);
      clr <= 1'h0;
      idle(2);
      chk(rxc, 1'h0);
      chk(txp, 1'h0);
      chk(mhi, 4'h1);
      chk({rts, dtr}, 2'h0);
      n = 0;
      repeat (8) begin
         @(negedge clk_i);
         n += baud;
      end
      chk(32'(n), 32'h8);
      rdchk(`ULSM_OFS_FLOW_THR, 8'h00);
      rdchk(`ULSM_OFS_LINE_STATUS, 8'h60);
      ben <= 4'h0;
      bus(1'h1, `ULSM_OFS_MODEM_CTRL, 8'hF0);
      ben <= 4'hF;
      rdchk(`ULSM_OFS_MODEM_CTRL, 8'h03);
      put(8'h22, 1'h1, 1'h1, 1'h0);
      @(negedge clk_i);
      chk({xany, xres}, 2'h0);
      $display("test normal_mode done");
      finish_test;
   end
endmodule : tb_uart_line_status_modem_ctrl
